// *** pkg/tbpwm_pkg.sv ***
// ==========================================================================
// shared constants of the timer based pwm block
// ==========================================================================
package tbpwm_pkg;

	// ======================================================================
	// widths
	// ======================================================================
	localparam int TB_W       = 8;   // base timer count width
	localparam int DUTY_W     = 10;  // duty and time base width
	localparam int QTR_W      = 2;   // low time base bits below the timer
	localparam int PRE_W      = 6;   // prescaler counter width
	localparam int PRE_SEL_W  = 2;
	localparam int POST_SEL_W = 4;
	localparam int ADDR_W     = 8;
	localparam int DATA_W     = 8;
	localparam int GAP_W      = 17;  // wide enough for 256 * 4 * 64 cycles

	// ======================================================================
	// register offsets
	// ======================================================================
	localparam logic [ADDR_W-1:0] ADDR_COUNT  = 8'h00;  // base_timer_count
	localparam logic [ADDR_W-1:0] ADDR_PERIOD = 8'h01;  // base_period_value
	localparam logic [ADDR_W-1:0] ADDR_TCTRL  = 8'h02;  // timer control
	localparam logic [ADDR_W-1:0] ADDR_LATCH  = 8'h03;  // port data latch
	localparam logic [ADDR_W-1:0] ADDR_DIR    = 8'h04;  // pin_direction
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h05;  // live channel levels
	localparam int                CH_SHIFT    = 2;      // four bytes per channel
	localparam logic [5:0]        CH_BASE_IDX = 6'h04;  // channel 0 at 8'h10
	localparam logic [1:0]        OFS_DCH     = 2'h0;   // duty_upper_byte
	localparam logic [1:0]        OFS_DCL     = 2'h1;   // duty_lower_bits
	localparam logic [1:0]        OFS_CON     = 2'h2;   // channel_control

	// ======================================================================
	// field positions
	// ======================================================================
	localparam int TCTRL_PRE_LSB  = 0;
	localparam int TCTRL_ON_BIT   = 2;
	localparam int TCTRL_POST_LSB = 3;
	localparam int DCL_LSB        = 6;
	localparam int CON_INV_BIT    = 4;  // output_invert
	localparam int CON_EN_BIT     = 7;

	// ======================================================================
	// reset values and timer constants
	// ======================================================================
	localparam logic [TB_W-1:0]  PERIOD_RST = 8'hff;
	localparam logic [QTR_W-1:0] QTR_LAST   = 2'h3;
	// prescaler terminal counts for 1:1, 1:4, 1:16, 1:64
	localparam logic [3:0][PRE_W-1:0] PRE_LIMITS = {6'h3f, 6'h0f, 6'h03, 6'h00};

endpackage : tbpwm_pkg

// *** pkg/tbpwm_tb_if.sv ***
`timescale 1ns/1ns
// ==========================================================================
// time base shared from the base timer to every channel
// ==========================================================================
interface tbpwm_tb_if;
	logic                          tick;     // time base advances this cycle
	logic                          load;     // increment cycle after period match
	logic [tbpwm_pkg::DUTY_W-1:0]  tb_next;  // time base after this edge

	modport timer (output tick, output load, output tb_next);
	modport chan  (input tick, input load, input tb_next);
endinterface : tbpwm_tb_if

// *** rtl/tbpwm_base_timer.sv ***
`timescale 1ns/1ns
// ==========================================================================
// base timer: prescaler, two quarter bits and the 8-bit count
// ==========================================================================
module tbpwm_base_timer (
	input  wire logic                              clk,
	input  wire logic                              arst_n,
	input  wire logic                              on,
	input  wire logic [tbpwm_pkg::PRE_SEL_W-1:0]   pre_sel,
	input  wire logic [tbpwm_pkg::TB_W-1:0]        period,
	input  wire logic                              count_we,
	input  wire logic [tbpwm_pkg::TB_W-1:0]        count_wdata,
	output logic      [tbpwm_pkg::TB_W-1:0]        count,
	tbpwm_tb_if.timer                              tb_bus
);

	typedef struct packed {
		logic [tbpwm_pkg::PRE_W-1:0] pre;
		logic [tbpwm_pkg::QTR_W-1:0] qtr;
		logic [tbpwm_pkg::TB_W-1:0]  cnt;
	} tbpwm_tmr_type;

	tbpwm_tmr_type s_reg;
	tbpwm_tmr_type s_next;
	logic          tick;
	logic          wrap;

	// ======================================================================
	// next state
	// ======================================================================
	// quarter bits count prescaler ticks, so the count moves every fourth
	always_comb begin
		s_next = s_reg;
		tick   = on && (s_reg.pre == tbpwm_pkg::PRE_LIMITS[pre_sel]);
		wrap   = tick && (s_reg.qtr == tbpwm_pkg::QTR_LAST);
		if (on) begin
			s_next.pre = tick ? '0 : s_reg.pre + 6'h01;
		end
		if (tick) begin
			s_next.qtr = s_reg.qtr + 2'h1;
		end
		if (wrap) begin
			// count clears on the increment after it equals the period
			s_next.cnt = (s_reg.cnt == period) ? '0 : s_reg.cnt + 8'h01;
		end
		// a software write loads the count and restarts the prescaler and quarter bits
		if (count_we) begin
			s_next.cnt = count_wdata;
			s_next.qtr = '0;
			s_next.pre = '0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ======================================================================
	// shared time base
	// ======================================================================
	assign count          = s_reg.cnt;
	assign tb_bus.tick    = tick && !count_we;
	assign tb_bus.load    = wrap && (s_reg.cnt == period) && !count_we;
	assign tb_bus.tb_next = {s_next.cnt, s_next.qtr};

endmodule : tbpwm_base_timer

// *** rtl/tbpwm_channel.sv ***
`timescale 1ns/1ns
// ==========================================================================
// one pwm channel: duty buffer, compare and polarity
// ==========================================================================
module tbpwm_channel (
	input  wire logic                           clk,
	input  wire logic                           arst_n,
	input  wire logic                           enable,
	input  wire logic                           invert,
	input  wire logic [tbpwm_pkg::DUTY_W-1:0]   duty_word,
	tbpwm_tb_if.chan                            tb_bus,
	output logic                                level,
	output logic                                pwm_out,
	output logic      [tbpwm_pkg::DUTY_W-1:0]   duty_active
);

	typedef struct packed {
		logic [tbpwm_pkg::DUTY_W-1:0] duty_buf;
		logic                         level;
		logic                         pin;
	} tbpwm_ch_type;

	tbpwm_ch_type s_reg;
	tbpwm_ch_type s_next;

	// ======================================================================
	// compare logic
	// ======================================================================
	// buffer reloads only at the period boundary, so mid-period writes wait
	always_comb begin
		s_next = s_reg;
		if (tb_bus.load) begin
			s_next.duty_buf = duty_word;
			s_next.level    = enable && (duty_word != '0);
		end else if (!enable) begin
			s_next.level = 1'b0;
		end else if (tb_bus.tick && (tb_bus.tb_next == s_reg.duty_buf)) begin
			// a duty beyond the period end never matches: stays active
			s_next.level = 1'b0;
		end
		s_next.pin = s_next.level ^ invert;
	end

	// buffer starts at zero so the output idles until the first load
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign level       = s_reg.level;
	assign pwm_out     = s_reg.pin;
	assign duty_active = s_reg.duty_buf;

endmodule : tbpwm_channel

// *** rtl/tbpwm_top.sv ***
`timescale 1ns/1ns
// ==========================================================================
// timer based pwm block with register port and pin multiplexer
// ==========================================================================
// How it works
// - ten-bit time base is timer count with two prescaled clock bits below
// - one timer period shared by all channels, each channel own duty
// - postscaler bits are stored only, never affect the outputs
// - every enabled channel with nonzero duty goes active when the timer count clears to zero
// - channel goes inactive when time base equals its ten-bit duty
// - duty at or beyond the period end keeps output active, full duty
// - count clears after period match; zero duty keeps output inactive
// - duty registers copy into active buffer only after a period match
// - duty writes allowed anytime, running period is not disturbed
// - invert bit in channel control flips output polarity
// - period is (period value + 1) * 4 * prescale clock cycles
// - pulse width is duty * prescale clock cycles
// - pin shows channel or port latch; direction bit low drives pin
module tbpwm_top #(
	parameter int N_CH = 2
) (
	input  wire logic                            clk,
	input  wire logic                            arst_n,
	input  wire logic [tbpwm_pkg::ADDR_W-1:0]    addr,
	input  wire logic [tbpwm_pkg::DATA_W-1:0]    wdata,
	input  wire logic                            wr_en,
	input  wire logic                            rd_en,
	output logic      [tbpwm_pkg::DATA_W-1:0]    rdata,
	output logic      [N_CH-1:0]                 pin_out,
	output logic      [N_CH-1:0]                 pin_oe
);

	localparam int DW    = tbpwm_pkg::DUTY_W;
	localparam int GAP_W = tbpwm_pkg::GAP_W;  // helper width, known before first use

	typedef struct packed {
		logic [tbpwm_pkg::TB_W-1:0]         period;
		logic                               tmr_on;
		logic [tbpwm_pkg::PRE_SEL_W-1:0]    pre_sel;
		logic [tbpwm_pkg::POST_SEL_W-1:0]   post_sel;
		logic [N_CH-1:0]                    latch;
		logic [N_CH-1:0]                    dir;
		logic [N_CH-1:0][7:0]               dch;
		logic [N_CH-1:0][1:0]               dcl;
		logic [N_CH-1:0]                    ch_en;
		logic [N_CH-1:0]                    ch_inv;
		logic [tbpwm_pkg::DATA_W-1:0]       rdata;
		logic [N_CH-1:0]                    pin_out;
		logic [N_CH-1:0]                    pin_oe;
		logic                               armed;
		logic [tbpwm_pkg::GAP_W-1:0]        gap;
		logic                               gap_valid;
	} tbpwm_regs_type;

	tbpwm_regs_type                 s_reg;
	tbpwm_regs_type                 s_next;
	logic [N_CH-1:0]                ch_hit;
	logic [N_CH-1:0]                ch_level;
	logic [N_CH-1:0]                ch_pin;
	logic [N_CH-1:0][DW-1:0]        duty_word;
	logic [N_CH-1:0][DW-1:0]        duty_act;
	logic [tbpwm_pkg::TB_W-1:0]     count;
	logic                           count_we;
	logic                           cfg_we;
	logic [tbpwm_pkg::GAP_W-1:0]    period_cycles;

	tbpwm_tb_if tb_bus ();

	// ======================================================================
	// base timer
	// ======================================================================
	assign count_we = wr_en && (addr == tbpwm_pkg::ADDR_COUNT);

	// the postscaler select never reaches the timer or the channels
	tbpwm_base_timer u_timer (
		.clk         (clk),
		.arst_n      (arst_n),
		.on          (s_reg.tmr_on),
		.pre_sel     (s_reg.pre_sel),
		.period      (s_reg.period),
		.count_we    (count_we),
		.count_wdata (wdata),
		.count       (count),
		.tb_bus      (tb_bus.timer)
	);

	// ======================================================================
	// channels
	// ======================================================================
	genvar c;
	generate
		for (c = 0; c < N_CH; c++) begin : g_ch
			// four byte window per channel above the timer registers
			assign ch_hit[c] = (addr[tbpwm_pkg::ADDR_W-1:tbpwm_pkg::CH_SHIFT]
				== 6'(tbpwm_pkg::CH_BASE_IDX + 6'(c)));
			assign duty_word[c] = {s_reg.dch[c], s_reg.dcl[c]};

			tbpwm_channel u_ch (
				.clk         (clk),
				.arst_n      (arst_n),
				.enable      (s_reg.ch_en[c]),
				.invert      (s_reg.ch_inv[c]),
				.duty_word   (duty_word[c]),
				.tb_bus      (tb_bus.chan),
				.level       (ch_level[c]),
				.pwm_out     (ch_pin[c]),
				.duty_active (duty_act[c])
			);
		end
	endgenerate

	// timing helper: one period in clock cycles at the live settings
	// largest case is 256 * 4 * 64, which still fits the helper width
	assign period_cycles = GAP_W'((GAP_W'(s_reg.period) + 17'h00001) * 17'h00004
		* (GAP_W'(tbpwm_pkg::PRE_LIMITS[s_reg.pre_sel]) + 17'h00001));

	// config writes that change the period length
	assign cfg_we = wr_en && ((addr == tbpwm_pkg::ADDR_COUNT)
		|| (addr == tbpwm_pkg::ADDR_PERIOD) || (addr == tbpwm_pkg::ADDR_TCTRL));

	// ======================================================================
	// register port and pin multiplexer
	// ======================================================================
	always_comb begin
		s_next       = s_reg;
		s_next.rdata = '0;  // read data stands one cycle only
		if (wr_en) begin
			case (addr)
				tbpwm_pkg::ADDR_PERIOD: begin
					s_next.period = wdata;
				end
				tbpwm_pkg::ADDR_TCTRL: begin
					s_next.tmr_on   = wdata[tbpwm_pkg::TCTRL_ON_BIT];
					s_next.pre_sel  = wdata[tbpwm_pkg::TCTRL_PRE_LSB +: 2];
					s_next.post_sel = wdata[tbpwm_pkg::TCTRL_POST_LSB +: 4];
				end
				tbpwm_pkg::ADDR_LATCH: begin
					s_next.latch = wdata[N_CH-1:0];
				end
				tbpwm_pkg::ADDR_DIR: begin
					s_next.dir = wdata[N_CH-1:0];
				end
				default: begin
				end
			endcase
			// duty writes land in the shadow copy only
			for (int i = 0; i < N_CH; i++) begin
				if (ch_hit[i]) begin
					case (addr[1:0])
						tbpwm_pkg::OFS_DCH: begin
							s_next.dch[i] = wdata;
						end
						tbpwm_pkg::OFS_DCL: begin
							s_next.dcl[i] = wdata[tbpwm_pkg::DCL_LSB +: 2];
						end
						tbpwm_pkg::OFS_CON: begin
							s_next.ch_en[i]  = wdata[tbpwm_pkg::CON_EN_BIT];
							s_next.ch_inv[i] = wdata[tbpwm_pkg::CON_INV_BIT];
						end
						default: begin
						end
					endcase
				end
			end
		end
		// unmapped addresses read as zero
		if (rd_en) begin
			case (addr)
				tbpwm_pkg::ADDR_COUNT:  s_next.rdata = count;
				tbpwm_pkg::ADDR_PERIOD: s_next.rdata = s_reg.period;
				tbpwm_pkg::ADDR_TCTRL: begin
					s_next.rdata[tbpwm_pkg::TCTRL_ON_BIT]       = s_reg.tmr_on;
					s_next.rdata[tbpwm_pkg::TCTRL_PRE_LSB +: 2]  = s_reg.pre_sel;
					s_next.rdata[tbpwm_pkg::TCTRL_POST_LSB +: 4] = s_reg.post_sel;
				end
				tbpwm_pkg::ADDR_LATCH:  s_next.rdata = 8'(s_reg.latch);
				tbpwm_pkg::ADDR_DIR:    s_next.rdata = 8'(s_reg.dir);
				tbpwm_pkg::ADDR_STATUS: s_next.rdata = 8'(ch_level);
				default: begin
				end
			endcase
			for (int i = 0; i < N_CH; i++) begin
				if (ch_hit[i]) begin
					case (addr[1:0])
						tbpwm_pkg::OFS_DCH: s_next.rdata = s_reg.dch[i];
						tbpwm_pkg::OFS_DCL: begin
							s_next.rdata[tbpwm_pkg::DCL_LSB +: 2] = s_reg.dcl[i];
						end
						tbpwm_pkg::OFS_CON: begin
							s_next.rdata[tbpwm_pkg::CON_EN_BIT]  = s_reg.ch_en[i];
							s_next.rdata[tbpwm_pkg::CON_INV_BIT] = s_reg.ch_inv[i];
						end
						default: begin
						end
					endcase
				end
			end
		end
		// enabled channel takes the pin, else the port latch shows
		for (int i = 0; i < N_CH; i++) begin
			s_next.pin_out[i] = s_reg.ch_en[i] ? ch_pin[i] : s_reg.latch[i];
			s_next.pin_oe[i]  = !s_reg.dir[i];
		end
		// period watch used by the checks below
		if (tb_bus.load) begin
			s_next.armed     = 1'b1;
			s_next.gap       = '0;
			s_next.gap_valid = 1'b1;
		end else if (s_reg.gap != '1) begin
			s_next.gap = s_reg.gap + 17'h00001;
		end
		if (cfg_we || !s_reg.tmr_on) begin
			s_next.gap_valid = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			// constants only, so the reset path never waits on logic
			s_reg        <= '0;
			s_reg.period <= tbpwm_pkg::PERIOD_RST;
			s_reg.dir    <= '1;  // all pins start as inputs
		end else begin
			s_reg <= s_next;
		end
	end

	assign rdata   = s_reg.rdata;
	assign pin_out = s_reg.pin_out;
	assign pin_oe  = s_reg.pin_oe;

	// ======================================================================
	// checks on channel 0 and the shared timer
	// ======================================================================
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	sequence s_load_nonzero;
		tb_bus.load && s_reg.ch_en[0] && (duty_word[0] != '0);
	endsequence

	sequence s_load_zero;
		tb_bus.load && (duty_word[0] == '0);
	endsequence

	property p_set_at_clear;
		s_load_nonzero |=> ch_level[0] && (count == '0);
	endproperty
	a_set_at_clear: assert property (p_set_at_clear)
		else $error("channel not active after timer clear");

	property p_zero_duty;
		s_load_zero |=> !ch_level[0];
	endproperty
	a_zero_duty: assert property (p_zero_duty)
		else $error("zero duty drove the output active");

	property p_clear_at_match;
		ch_level[0] && tb_bus.tick && !tb_bus.load
			&& (tb_bus.tb_next == duty_act[0]) |=> !ch_level[0];
	endproperty
	a_clear_at_match: assert property (p_clear_at_match)
		else $error("output not cleared at duty match");

	property p_full_duty;
		ch_level[0] && s_reg.ch_en[0] && !tb_bus.load && $stable(s_reg.period)
			&& (duty_act[0] > {s_reg.period, tbpwm_pkg::QTR_LAST}) |=> ch_level[0];
	endproperty
	a_full_duty: assert property (p_full_duty)
		else $error("full duty output was cleared");

	property p_buffer_load;
		tb_bus.load |=> (duty_act[0] == $past(duty_word[0]));
	endproperty
	a_buffer_load: assert property (p_buffer_load)
		else $error("duty buffer missed the period load");

	property p_buffer_hold;
		!tb_bus.load |=> $stable(duty_act[0]);
	endproperty
	a_buffer_hold: assert property (p_buffer_hold)
		else $error("duty buffer changed inside a period");

	property p_polarity;
		$stable(s_reg.ch_inv[0]) |-> (ch_pin[0] == (ch_level[0] ^ s_reg.ch_inv[0]));
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("channel polarity does not follow invert bit");

	property p_period_len;
		tb_bus.load && s_reg.gap_valid && !cfg_we |-> (s_reg.gap == period_cycles - 17'h00001);
	endproperty
	a_period_len: assert property (p_period_len)
		else $error("period length differs from programmed value");

	property p_min_period;
		tb_bus.load |=> !tb_bus.load [*3];
	endproperty
	a_min_period: assert property (p_min_period)
		else $error("period shorter than four time base steps");

	property p_pin_mux;
		##1 1'b1 |-> (pin_oe[0] == !$past(s_reg.dir[0]))
			&& (pin_out[0] == ($past(s_reg.ch_en[0]) ? $past(ch_pin[0]) : $past(s_reg.latch[0])));
	endproperty
	a_pin_mux: assert property (p_pin_mux)
		else $error("pin multiplexer shows the wrong source");

	property p_idle_after_reset;
		!s_reg.armed |-> !ch_level[0] && (duty_act[0] == '0);
	endproperty
	a_idle_after_reset: assert property (p_idle_after_reset)
		else $error("output active before first buffer load");

	// the count must restart even when no channel is enabled
	property p_count_clear;
		tb_bus.load |=> (count == '0);
	endproperty
	a_count_clear: assert property (p_count_clear)
		else $error("timer count not cleared after period match");

	// a rise away from the period start would stretch the pulse
	property p_rise_at_load;
		$rose(ch_level[0]) |-> $past(tb_bus.load);
	endproperty
	a_rise_at_load: assert property (p_rise_at_load)
		else $error("channel went active away from the timer clear");

	// pulse ends fall on time base steps, so width is whole ticks
	property p_fall_on_tick;
		$fell(ch_level[0]) && $past(s_reg.ch_en[0]) |-> $past(tb_bus.tick);
	endproperty
	a_fall_on_tick: assert property (p_fall_on_tick)
		else $error("channel went inactive between time base steps");

	// disabled channel leaves the pin to the port latch at level zero
	property p_disabled_idle;
		!s_reg.ch_en[0] |=> !ch_level[0];
	endproperty
	a_disabled_idle: assert property (p_disabled_idle)
		else $error("disabled channel level not idle");

endmodule : tbpwm_top

// *** tb/tbpwm_pin_load.sv ***
`timescale 1ns/1ns
// ==========================================================================
// external load on the multiplexed pins, with a pull-down on each pin
// ==========================================================================
module tbpwm_pin_load #(
	parameter int N = 2
) (
	input  wire logic [N-1:0] drv,
	input  wire logic [N-1:0] oe,
	output logic      [N-1:0] level
);
	// released pin falls to the pull-down, never keeps the old value
	assign level = oe & drv;
endmodule : tbpwm_pin_load

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
// ==========================================================================
// self-checking bench of the timer based pwm block
// ==========================================================================
module tb_top;
	logic       clk = 1'b0;
	logic       arst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr_en = 1'b0;
	logic       rd_en = 1'b0;
	logic [7:0] rdata;
	logic [1:0] pin_out;
	logic [1:0] pin_oe;
	logic [1:0] load;
	logic       rd_seen = 1'b0;
	logic [7:0] exp_q[$];
	logic [31:0] seed = 32'h2a1486ea;
	int         err_total = 0;
	int         total_checks = 0;
	int         duty;

	// ======================================================================
	// clock, design and load
	// ======================================================================
	always #25 clk = ~clk;

	tbpwm_top #(.N_CH(2)) tbpwm_top_i (.clk(clk), .arst_n(arst_n), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.pin_out(pin_out), .pin_oe(pin_oe));
	tbpwm_pin_load #(.N(2)) tbpwm_pin_load_i (.drv(pin_out), .oe(pin_oe), .level(load));

	// ======================================================================
	// helpers
	// ======================================================================
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
	endfunction : lfsr

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test

	// one-cycle strobes with a free cycle after, so no signal is set twice
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		exp_q.push_back(exp);
		@(posedge clk);
		rd_en <= 1'b0;
	endtask : rd

	// ======================================================================
	// read watcher: data stand only in the cycle after the strobe
	// ======================================================================
	always @(posedge clk) begin
		if (rd_seen) begin
			if (exp_q.size() > 0) begin
				check("rdata", {8'h00, rdata}, {8'h00, exp_q.pop_front()});
			end
		end
		rd_seen <= rd_en;
	end

	// bounded wait for a rising pin level; a hang is cut short here
	task automatic wait_rise(input int ch);
		int n;
		n = 0;
		while (!(load[ch] === 1'b0)) begin
			@(posedge clk);
			n++;
			if (n > 400) begin
				err_total++;
				end_of_test();
			end
		end
		while (!(load[ch] === 1'b1)) begin
			@(posedge clk);
			n++;
			if (n > 800) begin
				err_total++;
				end_of_test();
			end
		end
	endtask : wait_rise

	// skips one period so a change of setting has settled, then measures
	task automatic meas(input int hi, input int per);
		int h;
		int p;
		h = 0;
		p = 0;
		wait_rise(0);
		wait_rise(0);
		while (load[0] === 1'b1 && p < 600) begin
			@(posedge clk);
			h++;
			p++;
		end
		while (load[0] === 1'b0 && p < 600) begin
			@(posedge clk);
			p++;
		end
		check("high_width", h[15:0], hi[15:0]);
		check("period", p[15:0], per[15:0]);
	endtask : meas

	// counts cycles with the pin high over a fixed window
	task automatic ones(input int ch, input int win, input int exp);
		int k;
		k = 0;
		repeat (win) begin
			@(posedge clk);
			if (load[ch] === 1'b1) begin
				k++;
			end
		end
		check("pin_high_count", k[15:0], exp[15:0]);
	endtask : ones

	// ======================================================================
	// main sequence
	// ======================================================================
	initial begin
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		// reset values and refused addresses
		rd(tbpwm_pkg::ADDR_PERIOD, 8'hff);
		rd(tbpwm_pkg::ADDR_COUNT, 8'h00);
		rd(tbpwm_pkg::ADDR_DIR, 8'h03);
		wr(8'hfe, 8'h5a);
		rd(8'hfe, 8'h00);
		// pins driven: a disabled channel shows the port latch
		wr(tbpwm_pkg::ADDR_DIR, 8'h00);
		wr(tbpwm_pkg::ADDR_LATCH, 8'h03);
		rd(tbpwm_pkg::ADDR_LATCH, 8'h03);
		ones(1, 20, 20);
		// enabled but never loaded: idle until the first period match
		wr({tbpwm_pkg::CH_BASE_IDX, tbpwm_pkg::OFS_CON}, 8'h80);
		rd(tbpwm_pkg::ADDR_STATUS, 8'h00);
		ones(0, 20, 0);
		wr({tbpwm_pkg::CH_BASE_IDX, tbpwm_pkg::OFS_DCL}, 8'hff);
		rd({tbpwm_pkg::CH_BASE_IDX, tbpwm_pkg::OFS_DCL}, 8'hc0);
		// period 3, 1:1, postscale bits set to show they do nothing
		seed = lfsr(seed);
		duty = int'(seed[3:0] % 4'hf) + 1;
		wr(tbpwm_pkg::ADDR_PERIOD, 8'h03);
		rd(tbpwm_pkg::ADDR_PERIOD, 8'h03);
		wr({tbpwm_pkg::CH_BASE_IDX, tbpwm_pkg::OFS_DCH}, 8'(duty >> 2));
		wr({tbpwm_pkg::CH_BASE_IDX, tbpwm_pkg::OFS_DCL}, 8'(duty << 6));
		wr({tbpwm_pkg::CH_BASE_IDX + 6'h01, tbpwm_pkg::OFS_CON}, 8'h90);
		wr(tbpwm_pkg::ADDR_TCTRL, 8'h7c);
		meas(duty, 16);
		// zero duty, inverted: always high at the pin
		ones(1, 48, 48);
		// duty beyond the last time base value never clears
		wr({tbpwm_pkg::CH_BASE_IDX, tbpwm_pkg::OFS_DCH}, 8'h05);
		repeat (40) @(posedge clk);
		ones(0, 40, 40);
		// prescale 1:4 stretches period and pulse alike
		seed = lfsr(seed);
		duty = int'(seed[3:0] % 4'hf) + 1;
		wr({tbpwm_pkg::CH_BASE_IDX, tbpwm_pkg::OFS_DCH}, 8'(duty >> 2));
		wr({tbpwm_pkg::CH_BASE_IDX, tbpwm_pkg::OFS_DCL}, 8'(duty << 6));
		wr(tbpwm_pkg::ADDR_TCTRL, 8'h05);
		meas(4 * duty, 64);
		// pins back to input: the load sees its pull-down
		wr(tbpwm_pkg::ADDR_DIR, 8'h03);
		// output enable lags the write by two edges
		repeat (3) @(posedge clk);
		ones(1, 20, 0);
		end_of_test();
	end
endmodule : tb_top
